// file: core/dcw_cfg_mem.v
/*
 Small configuration memory with registered read data.
 Assumes one clock and synchronous active-high reset of the read register.
*/
`timescale 1ns/100ps
module dcw_cfg_mem #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire i_mclk,
	input wire i_rst,
	// Write port
	input wire i_we,
	input wire [AW-1:0] i_waddr,
	input wire [WIDTH-1:0] i_wdata,
	// Read port
	input wire [AW-1:0] i_raddr,
	output reg [WIDTH-1:0] o_rdata
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];

	// Storage write and registered read
	always @(posedge i_mclk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		if (i_rst) begin
			o_rdata <= {WIDTH{1'b0}};
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end
endmodule

// file: core/dcw_ctrl.v
/*
 Device control word register and its side effects: configuration save and
 reload against the non-volatile store, fault and retry clears, access key,
 forced alignment angle and the host keep-alive watchdog.
 Assumes the I2C slave decodes register strobes on i_mclk; the host leaves
 unlisted offsets alone.
*/
`timescale 1ns/100ps
`include "dcw_defines.vh"
module dcw_ctrl #(
	parameter [7:0] SAVE_KEY = 8'hA5,
	parameter CFG_WORDS = `DCW_CFG_WORDS,
	parameter KA_UNIT_CYC = `DCW_KA_UNIT_CYC
) (
	// Clock and reset
	input wire i_mclk,
	input wire i_rst,
	// Register access from the I2C slave
	input wire [7:0] i_reg_addr,
	input wire i_reg_wr,
	input wire i_reg_rd,
	input wire [31:0] i_reg_wdata,
	output reg [31:0] o_reg_rdata,
	output wire o_reg_hit,
	// Working configuration
	input wire [31:0] i_cfg_live,
	output reg [31:0] o_cfg_load,
	output reg [3:0] o_cfg_idx,
	output reg o_cfg_load_we,
	output reg o_nvm_busy,
	// Fault and alignment control
	output reg o_fault_clear_cmd,
	output reg o_retry_counter_clear_cmd,
	input wire i_force_align_en,
	output reg [8:0] o_align_angle,
	// Host keep-alive watchdog
	input wire i_i2c_mode,
	input wire [7:0] i_host_keepalive_interval,
	output reg o_wdt_fault
);
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_SAVE = 2'b01;
	localparam [1:0] ST_LOAD = 2'b10;
	localparam [1:0] ST_LOADW = 2'b11;

	reg save_bit;
	reg reload_bit;
	reg tickle_bit;
	reg [7:0] key;
	reg [8:0] angle_raw;
	reg [1:0] state;
	reg [3:0] idx;
	reg mem_we;
	reg [31:0] unit_cnt;
	reg [7:0] unit_ticks;
	wire [31:0] mem_rdata;
	wire wr_hit;

	// Reduce a 9-bit degree value into 0..359
	function [8:0] mod360;
		input [8:0] deg;
		begin
			if (deg >= `DCW_FULL_TURN) begin
				mod360 = deg - `DCW_FULL_TURN;
			end else begin
				mod360 = deg;
			end
		end
	endfunction

	assign o_reg_hit = (i_reg_addr == `DCW_OFFSET);
	assign wr_hit = i_reg_wr && o_reg_hit;

	// Command bits, key and angle fields
	always @(posedge i_mclk) begin
		if (i_rst) begin
			save_bit <= 1'b0;
			reload_bit <= 1'b0;
			tickle_bit <= 1'b0;
			key <= 8'h00;
			angle_raw <= 9'h000;
			o_fault_clear_cmd <= 1'b0;
			o_retry_counter_clear_cmd <= 1'b0;
		end else begin
			o_fault_clear_cmd <= wr_hit && i_reg_wdata[`DCW_FCLR_BIT];
			o_retry_counter_clear_cmd <= wr_hit && i_reg_wdata[`DCW_RCLR_BIT];
			// Tickle seen for one cycle, then cleared by hardware
			tickle_bit <= wr_hit && i_reg_wdata[`DCW_TICKLE_BIT];
			if (wr_hit) begin
				key <= i_reg_wdata[`DCW_KEY_HI:`DCW_KEY_LO];
				angle_raw <= i_reg_wdata[`DCW_ANG_HI:`DCW_ANG_LO];
			end
			// Command bits stay set until the operation finishes
			if (wr_hit && i_reg_wdata[`DCW_SAVE_BIT] && state == ST_IDLE) begin
				save_bit <= (i_reg_wdata[`DCW_KEY_HI:`DCW_KEY_LO] == SAVE_KEY);
			end else if (state == ST_SAVE && idx == CFG_WORDS - 1) begin
				save_bit <= 1'b0;
			end
			if (wr_hit && i_reg_wdata[`DCW_RELOAD_BIT] && state == ST_IDLE
				&& !(i_reg_wdata[`DCW_SAVE_BIT])) begin
				reload_bit <= 1'b1;
			end else if (state == ST_LOADW && idx == CFG_WORDS - 1) begin
				reload_bit <= 1'b0;
			end
		end
	end

	// Save and reload sequencer
	always @(posedge i_mclk) begin
		if (i_rst) begin
			state <= ST_IDLE;
			idx <= 4'h0;
			mem_we <= 1'b0;
			o_cfg_load <= 32'h00000000;
			o_cfg_idx <= 4'h0;
			o_cfg_load_we <= 1'b0;
			o_nvm_busy <= 1'b0;
		end else begin
			mem_we <= 1'b0;
			o_cfg_load_we <= 1'b0;
			case (state)
				ST_IDLE: begin
					idx <= 4'h0;
					o_cfg_idx <= 4'h0;
					o_nvm_busy <= 1'b0;
					if (save_bit) begin
						state <= ST_SAVE;
						mem_we <= 1'b1;
						o_nvm_busy <= 1'b1;
					end else if (reload_bit) begin
						state <= ST_LOAD;
						o_nvm_busy <= 1'b1;
					end
				end
				ST_SAVE: begin
					// Live word idx is written this cycle
					if (idx == CFG_WORDS - 1) begin
						state <= ST_IDLE;
					end else begin
						idx <= idx + 4'h1;
						o_cfg_idx <= idx + 4'h1;
						mem_we <= 1'b1;
					end
				end
				ST_LOAD: begin
					state <= ST_LOADW; // Wait for registered read
				end
				ST_LOADW: begin
					o_cfg_load <= mem_rdata;
					o_cfg_idx <= idx;
					o_cfg_load_we <= 1'b1;
					if (idx == CFG_WORDS - 1) begin
						state <= ST_IDLE;
					end else begin
						idx <= idx + 4'h1;
						state <= ST_LOAD;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Alignment angle applied only while forced alignment is on
	always @(posedge i_mclk) begin
		if (i_rst) begin
			o_align_angle <= 9'h000;
		end else if (i_force_align_en) begin
			o_align_angle <= mod360(angle_raw);
		end
	end

	// Keep-alive watchdog counting interval units
	always @(posedge i_mclk) begin
		if (i_rst) begin
			unit_cnt <= 32'h00000000;
			unit_ticks <= 8'h00;
			o_wdt_fault <= 1'b0;
		end else if (!i_i2c_mode || i_host_keepalive_interval == 8'h00 || tickle_bit) begin
			unit_cnt <= 32'h00000000;
			unit_ticks <= 8'h00;
		end else if (unit_cnt == KA_UNIT_CYC - 1) begin
			unit_cnt <= 32'h00000000;
			if (unit_ticks == i_host_keepalive_interval - 8'h01) begin
				o_wdt_fault <= 1'b1;
				unit_ticks <= 8'h00;
			end else begin
				unit_ticks <= unit_ticks + 8'h01;
			end
		end else begin
			unit_cnt <= unit_cnt + 32'h00000001;
		end
		if (!i_rst && o_fault_clear_cmd && !(unit_cnt == KA_UNIT_CYC - 1
			&& unit_ticks == i_host_keepalive_interval - 8'h01)) begin
			o_wdt_fault <= 1'b0;
		end
	end

	// Read-back: write-only fields read zero, reserved bits zero
	always @(posedge i_mclk) begin
		if (i_rst) begin
			o_reg_rdata <= `DCW_RESET;
		end else if (i_reg_rd && o_reg_hit) begin
			o_reg_rdata <= {save_bit, reload_bit, 19'h00000, tickle_bit, 10'h000};
		end
	end

	dcw_cfg_mem #(
		.WIDTH(32),
		.DEPTH(CFG_WORDS),
		.AW(4)
	) u_mem (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_we(mem_we),
		.i_waddr(idx),
		.i_wdata(i_cfg_live),
		.i_raddr(idx),
		.o_rdata(mem_rdata)
	);
endmodule

// file: inc/dcw_defines.vh
/*
 Constants for the device control word: offset, field positions, reset value
 and timing counts. Assumes a 10 MHz core clock.
*/
`ifndef DCW_DEFINES_VH
`define DCW_DEFINES_VH
`define DCW_OFFSET 8'hEA
`define DCW_RESET 32'h00000000
`define DCW_SAVE_BIT 31
`define DCW_RELOAD_BIT 30
`define DCW_FCLR_BIT 29
`define DCW_RCLR_BIT 28
`define DCW_KEY_HI 27
`define DCW_KEY_LO 20
`define DCW_ANG_HI 19
`define DCW_ANG_LO 11
`define DCW_TICKLE_BIT 10
`define DCW_FULL_TURN 9'h168
`define DCW_CLK_HZ 10000000
`define DCW_KA_UNIT_MS 1000
`define DCW_KA_UNIT_CYC ((`DCW_CLK_HZ / 1000) * `DCW_KA_UNIT_MS)
`define DCW_CFG_WORDS 16
`endif

// file: tb/dcw_ctrl_chk.sv
/* Port checker for the control word.
   Bound into dcw_ctrl. */
`timescale 1ns/100ps
module dcw_ctrl_chk #(
	parameter [7:0] SAVE_KEY = 8'hA5
) (
	input wire i_mclk,
	input wire i_rst,
	input wire [7:0] i_reg_addr,
	input wire i_reg_wr,
	input wire [31:0] i_reg_wdata,
	input wire [31:0] o_reg_rdata,
	input wire o_reg_hit,
	input wire i_force_align_en,
	input wire [8:0] o_align_angle,
	input wire o_nvm_busy,
	input wire o_fault_clear_cmd,
	input wire o_retry_counter_clear_cmd
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// Write to the control word
	wire wr_hit = i_reg_wr && o_reg_hit;
	wire [8:0] fld = i_reg_wdata[19:11];
	sequence s_save_req;
		wr_hit && i_reg_wdata[31] && !o_nvm_busy;
	endsequence
	a_fclr_pulse: assert property (wr_hit && i_reg_wdata[29] |=> o_fault_clear_cmd)
		else $error("fault clear pulse missing");
	a_rclr_pulse: assert property (wr_hit && i_reg_wdata[28] |=> o_retry_counter_clear_cmd)
		else $error("retry clear pulse missing");
	a_hit_map: assert property (o_reg_hit == (i_reg_addr == 8'hEA))
		else $error("offset decode wrong");
	a_resv_zero: assert property (o_reg_rdata[29:11] == 19'h0 && o_reg_rdata[9:0] == 10'h0)
		else $error("write-only or reserved bits read back");
	a_angle_mod: assert property (wr_hit && i_force_align_en ##1 i_force_align_en
		|=> o_align_angle == ($past(fld, 2) >= 9'h168 ?
		$past(fld, 2) - 9'h168 : $past(fld, 2)))
		else $error("align angle not modulo 360");
	a_angle_hold: assert property (!i_force_align_en |=> $stable(o_align_angle))
		else $error("align angle moved while disabled");
	a_save_go: assert property (s_save_req ##0 (i_reg_wdata[27:20] == SAVE_KEY) |-> ##[1:3] o_nvm_busy)
		else $error("save did not start");
	a_save_lock: assert property (s_save_req ##0 (i_reg_wdata[27:20] != SAVE_KEY && !i_reg_wdata[30])
		|=> !o_nvm_busy [*3])
		else $error("save started with wrong key");
	a_busy_run: assert property ($rose(o_nvm_busy) |-> o_nvm_busy [*8])
		else $error("store operation too short");
endmodule
bind dcw_ctrl dcw_ctrl_chk #(.SAVE_KEY(SAVE_KEY)) i_dcw_ctrl_chk (.i_mclk(i_mclk), .i_rst(i_rst),
	.i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
	.o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit), .i_force_align_en(i_force_align_en),
	.o_align_angle(o_align_angle), .o_nvm_busy(o_nvm_busy), .o_fault_clear_cmd(o_fault_clear_cmd),
	.o_retry_counter_clear_cmd(o_retry_counter_clear_cmd));

// file: tb/dcw_host.sv
/* Host model issuing register strobes.
   Assumes calls start off the rising edge. */
`timescale 1ns/100ps
module dcw_host (
	// Clock
	input wire i_mclk,
	// Register strobes
	output reg [7:0] o_addr,
	output reg o_wr,
	output reg o_rd,
	output reg [31:0] o_wdata
);
	initial begin
		o_addr = 8'hEA;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 32'h0;
	end
	// One-cycle strobe, released data inverted
	task acc(input w, input [7:0] a, input [31:0] d);
		begin
			@(negedge i_mclk);
			o_addr = a;
			o_wdata = d;
			o_wr = w;
			o_rd = !w;
			@(negedge i_mclk);
			o_wr = 1'b0;
			o_rd = 1'b0;
			o_wdata = ~d;
		end
	endtask
endmodule

// file: tb/tb_dcw_ctrl.sv
/* Testbench for dcw_ctrl.
   Assumes a 10 cycle keep-alive unit. */
`timescale 1ns/100ps
module tb_dcw_ctrl;
	reg i_mclk = 1'b0;
	reg i_rst = 1'b1;
	reg [31:0] cfg = 32'h0;
	reg aen = 1'b0;
	reg i2c = 1'b0;
	reg [7:0] ka = 8'h00;
	wire [7:0] addr;
	wire wr, rd, hit, busy, we, fclr, rclr, wdt;
	wire [31:0] wdata, rdata;
	wire [8:0] ang;
	wire [31:0] ld;
	wire [3:0] cidx;
	reg [31:0] salt = 32'h0;
	integer n_mismatch = 0;
	integer checked = 0;
	integer i, k, nwe, nb;
	reg [8:0] v;
	dcw_host i_dcw_host (.i_mclk(i_mclk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
	dcw_ctrl #(.KA_UNIT_CYC(10)) i_dcw_ctrl (.i_mclk(i_mclk), .i_rst(i_rst), .i_reg_addr(addr),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_hit(hit),
		.i_cfg_live(cfg), .o_cfg_load(ld), .o_cfg_idx(cidx), .o_cfg_load_we(we), .o_nvm_busy(busy),
		.o_fault_clear_cmd(fclr), .o_retry_counter_clear_cmd(rclr), .i_force_align_en(aen),
		.o_align_angle(ang), .i_i2c_mode(i2c), .i_host_keepalive_interval(ka), .o_wdt_fault(wdt));
	// Clock and live configuration, one word per store index
	always #50 i_mclk = ~i_mclk;
	always @(negedge i_mclk) cfg <= salt ^ {28'h0000000, cidx};
	function [8:0] amod(input [8:0] x);
		amod = (x >= 9'h168) ? x - 9'h168 : x;
	endfunction
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			checked = checked + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected %s: expected %h, seen %h", nm, e, g);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d, mismatches %0d", checked, n_mismatch);
			if (n_mismatch == 0 && checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// Write, then watch the store for 60 cycles
	task op(input [31:0] d);
		begin
			nwe = 0;
			nb = 0;
			i_dcw_host.acc(1'b1, 8'hEA, d);
			for (k = 0; k < 60; k = k + 1) begin
				@(negedge i_mclk);
				if (we === 1'b1) begin
					chk("reload index", nwe, {28'h0000000, cidx});
					chk("reload word", salt ^ nwe, ld);
				end
				nwe = nwe + (we === 1'b1);
				nb = nb + (busy === 1'b1);
			end
		end
	endtask
	// Watchdog on the whole run
	initial begin
		#300000;
		n_mismatch = n_mismatch + 1;
		tally_and_finish;
	end
	initial begin
		void'($urandom(32'hEA42));
		repeat (3) @(negedge i_mclk);
		i_rst = 1'b0;
		i_dcw_host.acc(1'b0, 8'hEA, 32'h0);
		chk("reset word", 32'h0, rdata);
		i_dcw_host.acc(1'b0, 8'hEC, 32'h0);
		chk("unlisted hit", 0, hit);
		$display("test reset done");
		aen = 1'b1;
		for (i = 0; i < 20; i = i + 1) begin
			v = (i == 0) ? 9'h167 : (i == 1) ? 9'h168 : (i == 2) ? 9'h1FF : 9'($urandom);
			i_dcw_host.acc(1'b1, 8'hEA, {2'b00, 10'($urandom), v, 11'($urandom)});
			@(negedge i_mclk);
			chk("angle", {23'h0, amod(v)}, {23'h0, ang});
		end
		aen = 1'b0;
		i_dcw_host.acc(1'b1, 8'hEA, 32'h000AA800);
		@(negedge i_mclk);
		chk("angle held", {23'h0, amod(v)}, {23'h0, ang});
		i_dcw_host.acc(1'b1, 8'hEA, 32'h00000400);
		repeat (3) @(negedge i_mclk);
		i_dcw_host.acc(1'b0, 8'hEA, 32'h0);
		chk("tickle", 32'h0, rdata);
		$display("test fields done");
		salt = $urandom;
		op(32'h85A00000);
		chk("bad key busy", 0, nb);
		op(32'h8A500000);
		chk("save busy", 1, nb >= 16);
		op(32'h40000000);
		chk("reload words", 16, nwe);
		$display("test store done");
		i2c = 1'b1;
		ka = 8'h01;
		for (i = 0; i < 10; i = i + 1) begin
			i_dcw_host.acc(1'b1, 8'hEA, 32'h00000400);
			repeat (3) @(negedge i_mclk);
		end
		chk("fed watchdog", 0, wdt);
		repeat (40) @(negedge i_mclk);
		chk("starved watchdog", 1, wdt);
		i2c = 1'b0;
		i_dcw_host.acc(1'b1, 8'hEA, 32'h30000000);
		chk("fault clear pulse", 1, fclr);
		chk("retry clear pulse", 1, rclr);
		@(negedge i_mclk);
		chk("fault clear ends", 0, fclr);
		chk("fault cleared", 0, wdt);
		$display("test watchdog done");
		tally_and_finish;
	end
endmodule
